// *** core/avcp_packer.sv ***
// Packs macroblock vectors, weight/offset pairs and coefficients into dwords
`timescale 1ns/1ps
`default_nettype none
module avcp_packer (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Vector load port from the bitstream decoder
    input  wire logic                          mv_wr_en,
    input  wire logic                          mv_wr_list,
    input  wire logic [avcp_pkg::UNIT_AW-1:0]  mv_wr_unit,
    input  wire logic [avcp_pkg::MV_IN_W-1:0]  mv_pred_horizontal,
    input  wire logic [avcp_pkg::MV_IN_W-1:0]  mv_pred_vertical,
    input  wire logic [avcp_pkg::MV_IN_W-1:0]  mv_delta_horizontal,
    input  wire logic [avcp_pkg::MV_IN_W-1:0]  mv_delta_vertical,
    // Macroblock descriptor
    input  wire logic                          mb_start,
    output var  logic                          mb_ready,
    input  wire logic [1:0]                    macroblock_type,
    input  wire logic [2*avcp_pkg::BLK_N-1:0]  sub_shape,
    input  wire logic                          raw_mode,
    input  wire logic [avcp_pkg::BLK_N-1:0]    l0_used,
    input  wire logic [avcp_pkg::BLK_N-1:0]    l1_used,
    input  wire logic                          wt_en,
    input  wire logic [3*avcp_pkg::BYTE_W-1:0] wt_l0_weight,
    input  wire logic [3*avcp_pkg::BYTE_W-1:0] wt_l0_offset,
    input  wire logic [3*avcp_pkg::BYTE_W-1:0] wt_l1_weight,
    input  wire logic [3*avcp_pkg::BYTE_W-1:0] wt_l1_offset,
    // Coefficient or raw sample stream
    input  wire logic                          coef_valid,
    output var  logic                          coef_ready,
    input  wire logic [avcp_pkg::DW_W-1:0]     coef_data,
    input  wire logic                          coef_last,
    // Packed output stream
    output var  logic                          out_valid,
    input  wire logic                          out_ready,
    output var  logic [avcp_pkg::DW_W-1:0]     out_data,
    output var  logic                          out_last
);
    import avcp_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_MV_RD, ST_MV_LD, ST_WT, ST_PAD1, ST_COEF, ST_PAD2} avcp_state_t;

    typedef struct packed {
        avcp_state_t             st;
        logic [IDX_W-1:0]        idx;
        logic [PH_W-1:0]         ph;
        logic                    mode4;
        avcp_mbt_t               mbt;
        logic [2*BLK_N-1:0]      sub;
        logic [BLK_N-1:0]        l0;
        logic [BLK_N-1:0]        l1;
        logic                    wten;
        logic [CMP_N*WO_W-1:0]   wo0;
        logic [CMP_N*WO_W-1:0]   wo1;
        avcp_kind_t              kind;
        logic                    out_valid;
        logic [DW_W-1:0]         out_data;
        logic                    out_last;
        logic                    mb_ready;
        logic                    coef_ready;
    } avcp_top_st_t;

    avcp_top_st_t q, d;

    function automatic logic [MV_OUT_W-1:0] sext_mv(input logic [MV_IN_W-1:0] v);
        return {{(MV_OUT_W-MV_IN_W){v[MV_IN_W-1]}}, v};
    endfunction : sext_mv

    // Source unit in the vector store for an output entry
    function automatic logic [UNIT_AW-1:0] src_unit(input logic mode4, input avcp_mbt_t mbt,
                                                    input logic [2*BLK_N-1:0] sub,
                                                    input logic [UNIT_AW-1:0] pos);
        logic [1:0] blk;
        logic [UNIT_AW-1:0] r;
        blk = mode4 ? pos[3:2] : pos[1:0];
        r   = {blk, 2'b00};
        if (mode4) begin
            case (avcp_sub_t'(sub[2*blk +: 2]))
                SUB_8X8: r = {blk, 2'b00};
                SUB_8X4: r = {blk, pos[1], 1'b0};
                SUB_4X8: r = {blk, 1'b0, pos[0]};
                default: r = pos;
            endcase
        end else begin
            case (mbt)
                MBT_16X16: r = 4'h0;
                MBT_16X8:  r = {blk[1], 3'b000};
                MBT_8X16:  r = {1'b0, blk[0], 2'b00};
                default:   r = {blk, 2'b00};
            endcase
        end
        return r;
    endfunction : src_unit

    // Block that an entry belongs to, for the list fallback flags
    function automatic logic [1:0] entry_blk(input logic mode4, input logic [UNIT_AW-1:0] pos);
        return mode4 ? pos[3:2] : pos[1:0];
    endfunction : entry_blk

    // List to read for a slot: {zero, list}
    function automatic logic [1:0] pick_list(input logic lst, input logic u0, input logic u1);
        logic own;
        logic oth;
        own = lst ? u1 : u0;
        oth = lst ? u0 : u1;
        if (own) begin
            return {1'b0, lst};
        end else if (oth) begin
            return {1'b0, ~lst};
        end
        return {1'b1, lst};
    endfunction : pick_list

    logic                  free;
    logic [IDX_W-1:0]      per_list;
    logic [IDX_W-1:0]      mv_total;
    logic [IDX_W-1:0]      wt_total;
    logic                  ent_list;
    logic [UNIT_AW-1:0]    ent_pos;
    logic [1:0]            ent_blk;
    logic [1:0]            sel;
    logic [MEM_AW-1:0]     rd_addr;
    logic [DW_W-1:0]       rd_data;
    logic [MEM_AW-1:0]     wr_addr;
    logic [DW_W-1:0]       wr_data;
    logic [MV_IN_W-1:0]    sum_h;
    logic [MV_IN_W-1:0]    sum_v;
    logic [1:0]            wt_slot;
    logic [1:0]            wt_grp;
    logic [1:0]            wsel0;
    logic [1:0]            wsel1;
    logic [WO_W-1:0]       wf0;
    logic [WO_W-1:0]       wf1;
    logic [CMP_N*WO_W-1:0] cap_wo0;
    logic [CMP_N*WO_W-1:0] cap_wo1;

    // Stored vectors are final ones: prediction plus delta
    assign sum_h   = mv_pred_horizontal + mv_delta_horizontal;
    assign sum_v   = mv_pred_vertical + mv_delta_vertical;
    assign wr_data = {sext_mv(sum_v), sext_mv(sum_h)};
    assign wr_addr = {mv_wr_list, mv_wr_unit};

    assign free     = !q.out_valid || out_ready;
    assign per_list = q.mode4 ? UNIT_ENTRIES : BLK_ENTRIES;
    assign mv_total = (|q.l1) ? IDX_W'(per_list << 1) : per_list;
    assign wt_total = (q.mbt == MBT_16X16) ? WT_DW_FULL : WT_DW_SPLIT;
    assign ent_list = q.mode4 ? q.idx[4] : q.idx[2];
    assign ent_pos  = q.mode4 ? q.idx[3:0] : {2'b00, q.idx[1:0]};
    assign ent_blk  = entry_blk(q.mode4, ent_pos);
    assign sel      = pick_list(ent_list, q.l0[ent_blk], q.l1[ent_blk]);
    assign rd_addr  = {sel[0], src_unit(q.mode4, q.mbt, q.sub, ent_pos)};

    // Weight dword: slot picks component, group picks 8x8 block
    assign wt_slot = q.idx[1:0];
    assign wt_grp  = q.idx[3:2];
    assign wsel0   = pick_list(1'b0, q.l0[wt_grp], q.l1[wt_grp]);
    assign wsel1   = pick_list(1'b1, q.l0[wt_grp], q.l1[wt_grp]);
    assign wf0 = wsel0[1] ? WO_ZERO : (wsel0[0] ? q.wo1[WO_W*wt_slot +: WO_W] : q.wo0[WO_W*wt_slot +: WO_W]);
    assign wf1 = wsel1[1] ? WO_ZERO : (wsel1[0] ? q.wo1[WO_W*wt_slot +: WO_W] : q.wo0[WO_W*wt_slot +: WO_W]);

    always_comb begin
        for (int c = 0; c < CMP_N; c++) begin
            cap_wo0[WO_W*c +: WO_W] = {wt_l0_weight[BYTE_W*c +: BYTE_W], wt_l0_offset[BYTE_W*c +: BYTE_W]};
            cap_wo1[WO_W*c +: WO_W] = {wt_l1_weight[BYTE_W*c +: BYTE_W], wt_l1_offset[BYTE_W*c +: BYTE_W]};
        end
    end

    avcp_vec_mem u_mem (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (mv_wr_en),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    always_comb begin
        d = q;
        if (q.out_valid && out_ready) begin
            d.out_valid = 1'b0;
            d.out_last  = 1'b0;
        end
        case (q.st)
            ST_IDLE: begin
                if (mb_start && q.mb_ready) begin
                    d.mbt   = avcp_mbt_t'(macroblock_type);
                    d.sub   = sub_shape;
                    d.mode4 = (avcp_mbt_t'(macroblock_type) == MBT_8X8) &&
                              (sub_shape != '0);
                    d.l0    = l0_used;
                    d.l1    = l1_used;
                    d.wten  = wt_en;
                    d.wo0   = cap_wo0;
                    d.wo1   = cap_wo1;
                    d.idx   = '0;
                    d.ph    = '0;
                    if (raw_mode) begin
                        d.st         = ST_COEF;
                        d.coef_ready = 1'b1;
                    end else begin
                        d.st = ST_MV_RD;
                    end
                end
            end
            ST_MV_RD: begin
                d.st = ST_MV_LD;
            end
            ST_MV_LD: begin
                if (free) begin
                    d.out_valid = 1'b1;
                    d.out_data  = sel[1] ? DW_ZERO : rd_data;
                    d.kind      = KIND_MV;
                    d.ph        = q.ph + 1'b1;
                    if (q.idx == mv_total - 1'b1) begin
                        d.idx = '0;
                        d.st  = q.wten ? ST_WT : ST_PAD1;
                    end else begin
                        d.idx = q.idx + 1'b1;
                        d.st  = ST_MV_RD;
                    end
                end
            end
            ST_WT: begin
                if (free) begin
                    d.out_valid = 1'b1;
                    d.kind      = KIND_WT;
                    // Slot 3 of each group is reserved; groups repeat the same set
                    d.out_data  = (wt_slot == WT_RSV_SLOT) ? DW_ZERO : {wf1, wf0};
                    d.ph        = q.ph + 1'b1;
                    if (q.idx == wt_total - 1'b1) begin
                        d.idx = '0;
                        d.st  = ST_PAD1;
                    end else begin
                        d.idx = q.idx + 1'b1;
                    end
                end
            end
            ST_PAD1: begin
                if (free) begin
                    if (q.ph == '0) begin
                        d.st         = ST_COEF;
                        d.coef_ready = 1'b1;
                    end else begin
                        d.out_valid = 1'b1;
                        d.out_data  = DW_ZERO;
                        d.kind      = KIND_PAD;
                        d.ph        = q.ph + 1'b1;
                    end
                end
            end
            ST_COEF: begin
                if (coef_valid && q.coef_ready) begin
                    d.out_valid  = 1'b1;
                    d.out_data   = coef_data;
                    d.kind       = KIND_COEF;
                    d.coef_ready = 1'b0;
                    d.ph         = q.ph + 1'b1;
                    if (coef_last) begin
                        if (q.ph == PH_LAST) begin
                            d.out_last = 1'b1;
                            d.st       = ST_IDLE;
                        end else begin
                            d.st = ST_PAD2;
                        end
                    end
                end else if (!q.coef_ready && free) begin
                    d.coef_ready = 1'b1;
                end
            end
            ST_PAD2: begin
                if (free) begin
                    d.out_valid = 1'b1;
                    d.out_data  = DW_ZERO;
                    d.kind      = KIND_PAD;
                    d.ph        = q.ph + 1'b1;
                    if (q.ph == PH_LAST) begin
                        d.out_last = 1'b1;
                        d.st       = ST_IDLE;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // A new macroblock waits until the previous last dword has left
        d.mb_ready = (d.st == ST_IDLE) && !d.out_valid;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_valid  = q.out_valid;
    assign out_data   = q.out_data;
    assign out_last   = q.out_last;
    assign mb_ready   = q.mb_ready;
    assign coef_ready = q.coef_ready;

    chk_mv_sign_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.out_valid && q.kind == KIND_MV) |->
            ((q.out_data[MV_V_LSB+MV_OUT_W-1 -: 4] == {4{q.out_data[MV_V_LSB+MV_IN_W-1]}}) &&
             (q.out_data[MV_H_LSB+MV_OUT_W-1 -: 4] == {4{q.out_data[MV_H_LSB+MV_IN_W-1]}})))
        else $error("vector component not sign extended");

    chk_raw_no_mv: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.st == ST_IDLE && mb_start && q.mb_ready && raw_mode) |=>
            (q.st == ST_COEF && !q.out_valid && q.coef_ready))
        else $error("raw macroblock did not go straight to samples");

    chk_mv_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.st == ST_MV_LD && free && d.st != ST_MV_RD) |->
            (q.idx == mv_total - 1'b1 && (q.mode4 || q.idx < UNIT_ENTRIES)))
        else $error("vector section ended at wrong count");

    chk_no_list1: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.st == ST_MV_LD && !(|q.l1)) |-> !ent_list)
        else $error("list-1 vector emitted while list-1 unused");

    chk_fallback_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.st == ST_MV_LD && free && !q.l0[ent_blk] && !q.l1[ent_blk]) |=>
            (q.out_valid && q.out_data == DW_ZERO))
        else $error("vector with no prediction not zero");

    chk_wt_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.st == ST_WT && free && q.idx[1:0] == WT_RSV_SLOT) |=>
            (q.kind == KIND_WT && q.out_data == DW_ZERO))
        else $error("reserved weight dword not zero");

    chk_wt_repeat: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.st == ST_WT && free && q.mbt == MBT_16X16 && q.idx[2] && wt_slot != WT_RSV_SLOT &&
         (&q.l0) && q.l1 == {BLK_N{q.l1[0]}}) |=>
            (q.out_valid && q.kind == KIND_WT &&
             q.out_data[WO_W-1:0] == $past(q.wo0[WO_W*wt_slot +: WO_W]) &&
             q.out_data[DW_W-1:WO_W] == $past(q.l1[0] ? q.wo1[WO_W*wt_slot +: WO_W] :
                                                        q.wo0[WO_W*wt_slot +: WO_W])))
        else $error("weight repeat dword differs");

    chk_pad_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.out_valid && q.kind == KIND_PAD) |-> (q.out_data == DW_ZERO))
        else $error("padding dword not zero");

    chk_last_aligned: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.out_valid && q.out_last) |-> (q.ph == '0 && q.st == ST_IDLE))
        else $error("macroblock end not on half line boundary");

    chk_out_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.out_valid && !out_ready) |=> (q.out_valid && $stable(q.out_data) && $stable(q.out_last)))
        else $error("output changed while stalled");

    chk_coef_after: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.out_valid && q.kind == KIND_COEF) |-> (q.st == ST_COEF || q.st == ST_PAD2 || q.st == ST_IDLE))
        else $error("coefficient emitted before vector section ended");

endmodule : avcp_packer
`default_nettype wire

// *** core/avcp_pkg.sv ***
// Constants and types shared by the motion vector and weight/offset packer
// Overview of operation
// - Sign-extend vector parts; vertical high, horizontal low
// - Pack macroblock vectors into half cache lines
// - Raw sample macroblock emits no vectors
// - Emit predicted plus delta, never delta alone
// - Vector count follows macroblock type: 4..32
// - Raster order inside blocks and across blocks
// - Zero vectors kept; no list-1 when unused
// - 16x16 replicated into four 8x8 entries
// - Each 16x8 half gives two identical entries
// - Each 8x16 half gives two identical entries
// - Plain 8x8 gives four separate block entries
// - Any sub-partition: sixteen 4x4 units, fixed scan
// - Sub-partitions replicate into their covered 4x4 units
// - List-0 slot: own, else list-1, else zero
// - List-1 slot: own, else list-0, else zero
// - Output padded to half cache line boundary
// - Vector data first, coefficient data after
// - Weight high byte, offset low byte, 16 bits
// - Weights per 8x8 entry, never finer
// - Luma, Cb, Cr dwords; list-0 low half
// - Weight fields follow the same list fallback
// - Dwords four to six repeat zero to two
package avcp_pkg;

    localparam int MV_IN_W      = 13;
    localparam int MV_OUT_W     = 16;
    localparam int DW_W         = 32;
    localparam int MV_H_LSB     = 0;
    localparam int MV_V_LSB     = 16;
    localparam int BYTE_W       = 8;
    localparam int WO_W         = 16;
    localparam int CMP_N        = 3;
    localparam int BLK_N        = 4;
    localparam int UNIT_AW      = 4;
    localparam int MEM_AW       = 5;
    localparam int MEM_DEPTH    = 32;
    localparam int IDX_W        = 6;
    localparam int PH_W         = 3;

    // Dwords in a half cache line (256 bits)
    localparam logic [PH_W-1:0]  PH_LAST      = 3'h7;
    localparam logic [IDX_W-1:0] BLK_ENTRIES  = 6'h04;
    localparam logic [IDX_W-1:0] UNIT_ENTRIES = 6'h10;
    localparam logic [IDX_W-1:0] WT_DW_FULL   = 6'h08;
    localparam logic [IDX_W-1:0] WT_DW_SPLIT  = 6'h10;
    localparam logic [1:0]       WT_RSV_SLOT  = 2'h3;
    localparam logic [DW_W-1:0]  DW_ZERO      = 32'h0000_0000;
    localparam logic [WO_W-1:0]  WO_ZERO      = 16'h0000;

    typedef enum logic [1:0] {MBT_16X16, MBT_16X8, MBT_8X16, MBT_8X8} avcp_mbt_t;
    typedef enum logic [1:0] {SUB_8X8, SUB_8X4, SUB_4X8, SUB_4X4} avcp_sub_t;
    typedef enum logic [1:0] {KIND_MV, KIND_WT, KIND_PAD, KIND_COEF} avcp_kind_t;

endpackage : avcp_pkg

// *** core/avcp_vec_mem.sv ***
// Vector store: one synchronous write port, registered read port
`timescale 1ns/1ps
`default_nettype none
module avcp_vec_mem (
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        wr_en,
    input  wire logic [avcp_pkg::MEM_AW-1:0] wr_addr,
    input  wire logic [avcp_pkg::DW_W-1:0]   wr_data,
    input  wire logic [avcp_pkg::MEM_AW-1:0] rd_addr,
    output var  logic [avcp_pkg::DW_W-1:0]   rd_data
);
    import avcp_pkg::*;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][DW_W-1:0] mem;
        logic [DW_W-1:0]                rd;
    } avcp_mem_st_t;

    avcp_mem_st_t q, d;

    always_comb begin
        d = q;
        if (wr_en) begin
            d.mem[wr_addr] = wr_data;
        end
        d.rd = q.mem[rd_addr];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd;

endmodule : avcp_vec_mem
`default_nettype wire

// *** verif/avcp_mem_model.sv ***
// Consumer model of the packed buffer: stalls at random and records every dword taken
`timescale 1ns/1ps
`default_nettype none
module avcp_mem_model (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      slow,
    input  wire logic                      out_valid,
    output var  logic                      out_ready,
    input  wire logic [avcp_pkg::DW_W-1:0] out_data,
    input  wire logic                      out_last
);
    import avcp_pkg::*;
    logic [DW_W:0] rx_q[$];
    int            seed = 32'h5305;
    // Slow mode accepts about one cycle in three
    always @(negedge core_clk) begin
        out_ready <= !slow || ($random(seed) % 3 == 0);
    end
    always @(posedge core_clk) begin
        if (rst_n && out_valid && out_ready) rx_q.push_back({out_last, out_data});
    end
endmodule : avcp_mem_model
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the packer: random macroblocks with corner cases
`timescale 1ns/1ps
`default_nettype none
module tb;
    import avcp_pkg::*;
    logic                core_clk, rst_n, mv_wr_en, mv_wr_list, mb_start, raw_mode, wt_en, slow;
    logic                coef_valid, coef_last, mb_ready, coef_ready, out_valid, out_ready, out_last;
    logic [UNIT_AW-1:0]  mv_wr_unit;
    logic [MV_IN_W-1:0]  ph, pv, dh, dv;
    logic [1:0]          mbt;
    logic [7:0]          sub;
    logic [3:0]          l0u, l1u, m0, m1;
    logic [23:0]         w0, o0, w1, o1;
    logic [DW_W-1:0]     coef_data, out_data, cb;
    logic [MV_IN_W-1:0]  mh[2][16];
    logic [MV_IN_W-1:0]  mvv[2][16];
    logic [DW_W:0]       exp_q[$];
    int                  seed = 32'h5305;
    int                  n_mismatch = 0;
    int                  n_compared = 0;
    avcp_packer i_avcp_packer (.core_clk(core_clk), .rst_n(rst_n), .mv_wr_en(mv_wr_en), .mv_wr_list(mv_wr_list),
        .mv_wr_unit(mv_wr_unit), .mv_pred_horizontal(ph), .mv_pred_vertical(pv), .mv_delta_horizontal(dh),
        .mv_delta_vertical(dv), .mb_start(mb_start), .mb_ready(mb_ready), .macroblock_type(mbt), .sub_shape(sub),
        .raw_mode(raw_mode), .l0_used(l0u), .l1_used(l1u), .wt_en(wt_en), .wt_l0_weight(w0), .wt_l0_offset(o0),
        .wt_l1_weight(w1), .wt_l1_offset(o1), .coef_valid(coef_valid), .coef_ready(coef_ready),
        .coef_data(coef_data), .coef_last(coef_last), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_last(out_last));
    avcp_mem_model i_avcp_mem_model (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [DW_W:0] seen, input logic [DW_W:0] expv);
        n_compared++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, expv, seen);
        end
    endtask : check
    task automatic wait_high(ref logic sig);
        for (int t = 0; sig !== 1'b1; t++) begin
            if (t > 3000) begin
                n_mismatch++;
                finish_test();
            end
            @(negedge core_clk);
        end
    endtask : wait_high
    // Flags shared by both blocks of each half of a 16x8 or 8x16 partition
    function automatic logic [3:0] norm(input logic [3:0] m);
        case (mbt)
            2'h0: return {4{m[0]}};
            2'h1: return {m[2], m[2], m[0], m[0]};
            2'h2: return {m[1], m[0], m[1], m[0]};
            default: return m;
        endcase
    endfunction : norm
    // Stored unit that supplies entry e after replication
    function automatic logic [3:0] src(input logic [3:0] e, input logic u16);
        logic [1:0] sh;
        sh = sub[2*e[3:2]+:2];
        if (u16) return {e[3:2], e[1] & sh[0], e[0] & sh[1]};
        return {e[1] & mbt[0], e[0] & mbt[1], 2'b00};
    endfunction : src
    function automatic logic [31:0] mvdw(input logic l, input logic [3:0] u, input logic [1:0] b);
        logic sl;
        sl = (l ? l1u[b] : l0u[b]) ? l : !l;
        if (!l0u[b] && !l1u[b]) return DW_ZERO;
        return {{3{mvv[sl][u][12]}}, mvv[sl][u], {3{mh[sl][u][12]}}, mh[sl][u]};
    endfunction : mvdw
    function automatic logic [15:0] wo(input logic l, input logic [1:0] g, input logic [1:0] c);
        logic sl;
        sl = (l ? l1u[g] : l0u[g]) ? l : !l;
        if (c == WT_RSV_SLOT || (!l0u[g] && !l1u[g])) return WO_ZERO;
        return sl ? {w1[8*c+:8], o1[8*c+:8]} : {w0[8*c+:8], o0[8*c+:8]};
    endfunction : wo
    task automatic build_exp(input int nc);
        logic u16;
        u16 = (mbt == MBT_8X8) && (sub != 8'h00);
        exp_q.delete();
        for (int l = 0; l < 2 && !raw_mode; l++) begin
            for (int e = 0; e < (u16 ? 16 : 4) && (l == 0 || l1u != 4'h0); e++) begin
                exp_q.push_back({1'b0, mvdw(l[0], src(e[3:0], u16), u16 ? e[3:2] : e[1:0])});
            end
        end
        for (int k = 0; k < (mbt == MBT_16X16 ? 8 : 16) && wt_en && !raw_mode; k++) begin
            exp_q.push_back({1'b0, wo(1'b1, k[3:2], k[1:0]), wo(1'b0, k[3:2], k[1:0])});
        end
        while (exp_q.size() % 8 != 0) exp_q.push_back(33'h0_0000_0000);
        for (int c = 0; c < nc; c++) exp_q.push_back({1'b0, cb + c});
        while (exp_q.size() % 8 != 0) exp_q.push_back(33'h0_0000_0000);
        exp_q[$][32] = 1'b1;
    endtask : build_exp
    task automatic run_mb(input int i);
        int nc;
        wait_high(mb_ready);
        {mbt, sub, m0, m1, raw_mode, wt_en, slow} = 21'($random(seed));
        {w0, o0, w1, o1} = {$random(seed), $random(seed), $random(seed)};
        cb = $random(seed);
        nc = ($random(seed) & 7) + 1;
        raw_mode = raw_mode & (i % 4 == 3);
        case (i)
            0: {mbt, m0, m1, wt_en, nc} = {2'h0, 4'hF, 4'h0, 1'b1, 32'd1};
            1, 2: {mbt, wt_en, raw_mode} = {i[1:0], 2'b10};
            3, 7: {mbt, sub, m0, m1, raw_mode} = {2'h3, 8'h00, 4'h5, 4'hA, 1'b0};
            4: {mbt, sub, raw_mode} = {2'h3, 8'hE4, 1'b0};
            5: raw_mode = 1'b1;
            6: {m0, m1} = 8'h00;
            default: ;
        endcase
        l0u = norm(m0);
        l1u = norm(m1);
        for (int a = 0; a < 32; a++) begin
            {ph, pv, dh, dv} = (i == 8) ? 52'h0 : 52'({$random(seed), $random(seed)});
            mv_wr_en = 1'b1;
            {mv_wr_list, mv_wr_unit} = a[4:0];
            mh[a[4]][a[3:0]] = ph + dh;
            mvv[a[4]][a[3:0]] = pv + dv;
            @(negedge core_clk);
        end
        mv_wr_en = 1'b0;
        i_avcp_mem_model.rx_q.delete();
        build_exp(nc);
        mb_start = 1'b1;
        @(negedge core_clk);
        mb_start = 1'b0;
        for (int c = 0; c < nc; c++) begin
            {coef_valid, coef_data, coef_last} = {1'b1, cb + c, c == nc - 1};
            wait_high(coef_ready);
            @(negedge core_clk);
        end
        coef_valid = 1'b0;
        wait_high(mb_ready);
        check("count", 33'(i_avcp_mem_model.rx_q.size()), 33'(exp_q.size()));
        foreach (exp_q[k]) check("dword", i_avcp_mem_model.rx_q[k], exp_q[k]);
    endtask : run_mb
    initial begin
        {rst_n, mv_wr_en, mv_wr_list, mb_start, raw_mode, wt_en, coef_valid, coef_last, slow} = 9'h000;
        {mv_wr_unit, ph, pv, dh, dv, mbt, sub, l0u, l1u} = '0;
        {w0, o0, w1, o1, coef_data} = '0;
        repeat (10) @(negedge core_clk);
        check("reset", {out_last, out_data}, 33'h0);
        check("reset_flags", {30'h0, out_valid, mb_ready, coef_ready}, 33'h0);
        rst_n = 1'b1;
        for (int i = 0; i < 40; i++) run_mb(i);
        finish_test();
    end
endmodule : tb
`default_nettype wire
